/* File: hw/lrf_pkg.sv */
package lrf_pkg;
	// ==========================================
	// Register byte offsets
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_SCALE = 8'h04;
	localparam logic [7:0] OFS_OFFSET = 8'h08;
	localparam logic [7:0] OFS_DELAY = 8'h0c;
	localparam logic [7:0] OFS_FSLVL = 8'h10;
	localparam logic [7:0] OFS_SPAN = 8'h14;
	localparam logic [7:0] OFS_RATE = 8'h18;
	localparam logic [7:0] OFS_STATUS = 8'h1c;
	localparam logic [7:0] OFS_LEVEL = 8'h20;
	localparam logic [7:0] OFS_DISP = 8'h24;
	// ==========================================
	// Control field positions
	localparam int CTRL_DP_LO = 0;
	localparam int CTRL_AM_LO = 2;
	localparam int CTRL_CH_LO = 4;
	localparam int CTRL_PCT = 6;
	localparam int CTRL_RLY_LO = 8;
	// ==========================================
	// Fixed point: values in thousandths of a unit
	localparam logic signed [31:0] MILLI = 32'sh0000_03e8;
	localparam logic signed [31:0] LIM_LO = -32'sh000f_3e58;
	localparam logic signed [31:0] LIM_HI = 32'sh0098_9298;
	localparam logic signed [31:0] PCT_FULL = 32'sh0001_86a0;
	localparam logic signed [31:0] PCT_LO = -32'sh0000_c350;
	localparam logic signed [31:0] PCT_HI = 32'sh0002_49f0;
	localparam logic [31:0] DIGIT_MAX = 32'h0001_869f;
	// ==========================================
	// Reset values
	localparam logic [1:0] DP_RST = 2'h2;
	localparam logic signed [31:0] SCALE_RST = 32'sh0000_03e8;
	localparam logic [31:0] DELAY_RST = 32'h0000_03e8;
	localparam logic [31:0] SPAN_RST = 32'h0000_3a98;
	localparam logic [15:0] STEP_RST = 16'h0064;
	// ==========================================
	// Timing: the failsafe delay counts hundredths of a minute
	localparam int CLK_KHZ = 125000;
	localparam int TICK_MS = 600;
	localparam int TICK_CYC = TICK_MS * CLK_KHZ;
	// ==========================================
	// Enumerations
	typedef enum logic [1:0] {CH_NUMERIC, CH_GO_FULL_SPAN, CH_GO_EMPTY, CH_HOLD} lrf_choice_e;
	typedef enum logic [1:0] {AM_NONE, AM_RESTRICTED, AM_IMMEDIATE, AM_FAST_BACK} lrf_approach_e;
	typedef enum logic [1:0] {FC_ECHO_LOST, FC_SHORT, FC_CUT, FC_GENERIC} lrf_fault_e;
	typedef enum logic [1:0] {LS_MEASURE, LS_WAIT, LS_FAILSAFE, LS_RETURN} lrf_lstate_e;
endpackage

/* File: hw/lrf_slew.sv */
`timescale 1ns/1ps
// ==========================================
// Moves a level toward a target by at most one step per tick
module lrf_slew
	import lrf_pkg::*;
(
	// Levels
	input wire logic signed [31:0] cur,
	input wire logic signed [31:0] tgt,
	// Limits per tick
	input wire logic [15:0] step_up,
	input wire logic [15:0] step_dn,
	input wire logic tick,
	// Result
	output logic signed [31:0] nxt
);
	logic signed [31:0] up;
	logic signed [31:0] dn;
	// Zero-extended steps keep the rate sign-safe
	assign up = signed'({16'h0000, step_up});
	assign dn = signed'({16'h0000, step_dn});
	// Clip the change to the fill or empty limit
	always_comb begin
		nxt = cur;
		if (tick) begin
			if (tgt > cur) begin
				nxt = (tgt - cur > up) ? cur + up : tgt;
			end else if (tgt < cur) begin
				nxt = (cur - tgt > dn) ? cur - dn : tgt;
			end
		end
	end
endmodule // lrf_slew

/* File: hw/lrf_core.sv */
// Register access over APB and the address map are this design's own decisions.
`timescale 1ns/1ps
// What this block does
// RQ1 - Show zero to three decimals per decimal_places_setting, default two
// RQ2 - Drop decimals automatically when the reading would not fit the display
// RQ3 - Multiply the reading by reading_scale_factor, range -999..9999, default 1.000
// RQ4 - Show overflow_indicator when more than five digits are needed
// RQ5 - Add reading_offset, default 0.000, to the displayed reading
// RQ6 - Offset affects display only; control level stays relative to empty
// RQ7 - Enter failsafe only after invalid measurements last failsafe_delay
// RQ8 - In failsafe, substitute the failsafe level for the material level
// RQ9 - In failsafe show echo lost, shorted, cut or generic fault code
// RQ10 - Failsafe level: numeric, full span, empty, or hold last reading
// RQ11 - Numeric failsafe level in units or percent, limited -50..150% span
// RQ12 - Each relay follows its failsafe response; release or track the level
// RQ13 - Mode 1 approaches and leaves the failsafe level at limited rate
// RQ14 - Mode 2 adopts the failsafe level at once
// RQ15 - Mode 3 approaches at limited rate, returns straight to measurement
// RQ16 - A valid measurement restarts the timer and leaves failsafe
module lrf_core
	import lrf_pkg::*;
#(
	parameter int RELAY_N = 5,
	parameter logic [RELAY_N-1:0] RELAY_FS_RST = 5'h03,
	parameter int TICK_CYCLES = TICK_CYC
) (
	// Clock and reset
	input wire logic CORE_CLK,
	input wire logic RST,
	// APB slave
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic PWRITE,
	input wire logic [7:0] PADDR,
	input wire logic [31:0] PWDATA,
	output logic [31:0] PRDATA,
	output logic PREADY,
	output logic PSLVERR,
	// Measurement from the transducer logic
	input wire logic MEAS_STB,
	input wire logic MEAS_OK,
	input wire logic [1:0] MEAS_FAULT,
	input wire logic signed [31:0] MEAS_LEVEL,
	// Level used by relay control
	output logic signed [31:0] CTRL_LEVEL,
	output logic FAILSAFE,
	output logic [RELAY_N-1:0] FORCE_RELEASE,
	// Display
	output logic [16:0] DISP_DIGITS,
	output logic DISP_NEG,
	output logic [1:0] DISP_DP,
	output logic DISP_OVERFLOW,
	output logic DISP_FAULT_SHOW,
	output logic [1:0] DISP_FAULT
);
	// ==========================================
	// State
	typedef struct packed {
		logic [31:0] rdata;
		logic ready;
		logic slverr;
		logic [1:0] dp_set;
		lrf_approach_e am;
		lrf_choice_e ch;
		logic pct;
		logic [RELAY_N-1:0] rly;
		logic signed [31:0] scale;
		logic signed [31:0] offset;
		logic [31:0] delay;
		logic signed [31:0] fs_val;
		logic signed [31:0] span;
		logic [15:0] fill;
		logic [15:0] empty;
		lrf_lstate_e ls;
		lrf_approach_e am_fs;
		logic [31:0] pre;
		logic tick;
		logic [31:0] tmr;
		logic signed [31:0] meas;
		logic signed [31:0] hold;
		logic signed [31:0] rep;
		lrf_fault_e fault;
		logic [16:0] digits;
		logic neg;
		logic [1:0] dp;
		logic ovf;
		logic fs;
		logic [RELAY_N-1:0] frel;
	} lrf_core_s;

	lrf_core_s st_q;
	lrf_core_s st_d;
	logic signed [31:0] slew_tgt;
	logic signed [31:0] slew_nxt;
	logic signed [31:0] fs_lvl;
	logic signed [63:0] prod;
	logic signed [31:0] shown;
	logic [31:0] mag;
	logic [31:0] dv [4];
	logic wr_acc;

	// ==========================================
	// Helpers
	function automatic logic signed [31:0] clip(input logic signed [31:0] v,
		input logic signed [31:0] lo, input logic signed [31:0] hi);
		clip = (v < lo) ? lo : ((v > hi) ? hi : v);
	endfunction

	// Rate limiter shared by approach and return
	lrf_slew u_slew (
		.cur(st_q.rep),
		.tgt(slew_tgt),
		.step_up(st_q.fill),
		.step_dn(st_q.empty),
		.tick(st_q.tick),
		.nxt(slew_nxt)
	);

	// ==========================================
	// Failsafe target level
	always_comb begin
		prod = 64'sh0;
		fs_lvl = st_q.hold;
		case (st_q.ch)
			CH_NUMERIC: begin
				if (st_q.pct) begin
					// Percent of span, clipped to the allowed band
					prod = 64'(clip(st_q.fs_val, PCT_LO, PCT_HI)) * 64'(st_q.span); // RQ11
					fs_lvl = 32'(prod / 64'(PCT_FULL)); // RQ11
				end else begin
					fs_lvl = clip(st_q.fs_val, -(st_q.span >>> 1),
						st_q.span + (st_q.span >>> 1)); // RQ11
				end
			end
			CH_GO_FULL_SPAN: fs_lvl = st_q.span; // RQ10
			CH_GO_EMPTY: fs_lvl = 32'sh0; // RQ10
			CH_HOLD: fs_lvl = st_q.hold; // RQ10
			default: fs_lvl = st_q.hold;
		endcase
	end

	// Limiter heads for failsafe level in failsafe, else for measurement
	assign slew_tgt = (st_q.ls == LS_FAILSAFE) ? fs_lvl : st_q.meas;

	// ==========================================
	// Display scaling; offset never touches the control level
	always_comb begin
		shown = 32'(64'(st_q.rep) * 64'(st_q.scale) / 64'(MILLI)) + st_q.offset; // RQ3 RQ5 RQ6
		mag = shown[31] ? 32'(-shown) : shown;
		dv[3] = mag;
		dv[2] = mag / 32'd10;
		dv[1] = mag / 32'd100;
		dv[0] = mag / 32'd1000;
	end

	assign wr_acc = PSEL && PENABLE && st_q.ready && PWRITE;

	// ==========================================
	// Next state
	always_comb begin
		st_d = st_q;
		// APB: read data latched in setup, access completes next cycle
		st_d.ready = PSEL && !PENABLE;
		st_d.slverr = 1'b0;
		if (PSEL && !PENABLE) begin
			st_d.rdata = 32'h0;
			st_d.slverr = 1'b0;
			case (PADDR)
				OFS_CTRL: begin
					st_d.rdata[CTRL_DP_LO +: 2] = st_q.dp_set;
					st_d.rdata[CTRL_AM_LO +: 2] = st_q.am;
					st_d.rdata[CTRL_CH_LO +: 2] = st_q.ch;
					st_d.rdata[CTRL_PCT] = st_q.pct;
					st_d.rdata[CTRL_RLY_LO +: RELAY_N] = st_q.rly;
				end
				OFS_SCALE: st_d.rdata = st_q.scale;
				OFS_OFFSET: st_d.rdata = st_q.offset;
				OFS_DELAY: st_d.rdata = st_q.delay;
				OFS_FSLVL: st_d.rdata = st_q.fs_val;
				OFS_SPAN: st_d.rdata = st_q.span;
				OFS_RATE: st_d.rdata = {st_q.empty, st_q.fill};
				OFS_STATUS: st_d.rdata = {25'h0, st_q.ovf, st_q.dp, st_q.fault, st_q.ls};
				OFS_LEVEL: st_d.rdata = st_q.rep;
				OFS_DISP: st_d.rdata = {st_q.neg, 14'h0, st_q.digits};
				default: st_d.slverr = 1'b1;
			endcase
		end
		// Writes take effect at the completing edge
		if (wr_acc) begin
			case (PADDR)
				OFS_CTRL: begin
					st_d.dp_set = PWDATA[CTRL_DP_LO +: 2]; // RQ1
					st_d.am = (PWDATA[CTRL_AM_LO +: 2] == 2'h0) ? AM_RESTRICTED
						: lrf_approach_e'(PWDATA[CTRL_AM_LO +: 2]);
					st_d.ch = lrf_choice_e'(PWDATA[CTRL_CH_LO +: 2]);
					st_d.pct = PWDATA[CTRL_PCT];
					st_d.rly = PWDATA[CTRL_RLY_LO +: RELAY_N];
				end
				OFS_SCALE: st_d.scale = clip(signed'(PWDATA), LIM_LO, LIM_HI); // RQ3
				OFS_OFFSET: st_d.offset = clip(signed'(PWDATA), LIM_LO, LIM_HI); // RQ5
				OFS_DELAY: st_d.delay = PWDATA;
				OFS_FSLVL: st_d.fs_val = signed'(PWDATA);
				OFS_SPAN: st_d.span = signed'(PWDATA);
				OFS_RATE: begin
					st_d.fill = PWDATA[15:0];
					st_d.empty = PWDATA[31:16];
				end
				default: st_d.span = st_q.span;
			endcase
		end

		// Hundredth-of-a-minute tick
		st_d.tick = 1'b0;
		if (st_q.pre >= 32'(TICK_CYCLES - 1)) begin
			st_d.pre = 32'h0;
			st_d.tick = 1'b1;
		end else begin
			st_d.pre = st_q.pre + 32'h1;
		end

		// Measurement tracking and failsafe sequence
		if (MEAS_STB && MEAS_OK) begin
			st_d.meas = MEAS_LEVEL;
		end
		case (st_q.ls)
			LS_MEASURE: begin
				st_d.rep = st_d.meas;
				st_d.tmr = 32'h0;
				if (MEAS_STB && !MEAS_OK) begin
					st_d.fault = lrf_fault_e'(MEAS_FAULT);
					st_d.ls = LS_WAIT;
				end
			end
			LS_WAIT: begin
				if (MEAS_STB && MEAS_OK) begin
					st_d.ls = LS_MEASURE; // RQ16
					st_d.rep = MEAS_LEVEL;
				end else if (st_q.tmr >= st_q.delay) begin
					// Latch level and approach mode at entry
					st_d.ls = LS_FAILSAFE; // RQ7
					st_d.hold = st_q.rep; // RQ10
					st_d.am_fs = st_q.am;
					if (st_q.am == AM_IMMEDIATE) begin
						// Hold latch is updated only at this edge, so keep the level
						st_d.rep = (st_q.ch == CH_HOLD) ? st_q.rep : fs_lvl; // RQ14
					end
				end else if (st_q.tick) begin
					st_d.tmr = st_q.tmr + 32'h1; // RQ7
				end
				if (MEAS_STB && !MEAS_OK) begin
					st_d.fault = lrf_fault_e'(MEAS_FAULT);
				end
			end
			LS_FAILSAFE: begin
				if (st_q.am_fs == AM_IMMEDIATE) begin
					st_d.rep = fs_lvl; // RQ8 RQ14
				end else begin
					st_d.rep = slew_nxt; // RQ8 RQ13 RQ15
				end
				if (MEAS_STB && !MEAS_OK) begin
					st_d.fault = lrf_fault_e'(MEAS_FAULT); // RQ9
				end
				if (MEAS_STB && MEAS_OK) begin
					st_d.tmr = 32'h0; // RQ16
					if (st_q.am_fs == AM_RESTRICTED) begin
						st_d.ls = LS_RETURN; // RQ13
					end else begin
						st_d.ls = LS_MEASURE; // RQ15 RQ16
						st_d.rep = MEAS_LEVEL; // RQ15
					end
				end
			end
			LS_RETURN: begin
				// Rate-limited return to the live measurement
				st_d.rep = slew_nxt; // RQ13
				if (MEAS_STB && !MEAS_OK) begin
					st_d.fault = lrf_fault_e'(MEAS_FAULT);
					st_d.ls = LS_WAIT;
				end else if (slew_nxt == st_q.meas) begin
					st_d.ls = LS_MEASURE;
				end
			end
			default: st_d.ls = LS_MEASURE;
		endcase

		// Decimal places: highest setting that still fits five digits
		st_d.ovf = 1'b1;
		st_d.dp = 2'h0;
		st_d.digits = 17'h0;
		for (int k = 0; k < 4; k++) begin
			if (2'(k) <= st_q.dp_set && dv[k] <= DIGIT_MAX) begin
				st_d.dp = 2'(k); // RQ1 RQ2
				st_d.digits = dv[k][16:0];
				st_d.ovf = 1'b0; // RQ4
			end
		end
		if (st_d.ovf) begin
			st_d.digits = 17'h0; // RQ4
		end
		st_d.neg = shown[31] && !st_d.ovf;
		// Failsafe flags registered so the outputs come from flip-flops
		st_d.fs = (st_d.ls == LS_FAILSAFE); // RQ9
		st_d.frel = (st_d.ls == LS_FAILSAFE) ? st_d.rly : '0; // RQ12
	end

	// ==========================================
	// Registers
	always_ff @(posedge CORE_CLK) begin
		if (RST) begin
			st_q <= '0;
			st_q.dp_set <= DP_RST; // RQ1
			st_q.am <= AM_RESTRICTED; // RQ13
			st_q.ch <= CH_HOLD; // RQ10
			st_q.rly <= RELAY_FS_RST; // RQ12
			st_q.scale <= SCALE_RST; // RQ3
			st_q.delay <= DELAY_RST; // RQ7
			st_q.span <= signed'(SPAN_RST);
			st_q.fill <= STEP_RST;
			st_q.empty <= STEP_RST;
			st_q.ls <= LS_MEASURE;
			st_q.am_fs <= AM_RESTRICTED;
			st_q.fault <= FC_GENERIC;
			st_q.ovf <= 1'b0;
		end else begin
			st_q <= st_d;
		end
	end

	// ==========================================
	// Outputs, all from flip-flops
	assign PRDATA = st_q.rdata;
	assign PREADY = st_q.ready;
	assign PSLVERR = st_q.slverr;
	// Control sees the substituted level, never the offset
	assign CTRL_LEVEL = st_q.rep; // RQ6 RQ8
	assign FAILSAFE = st_q.fs;
	// Released relays ignore the level; the rest track it
	assign FORCE_RELEASE = st_q.frel; // RQ12
	assign DISP_DIGITS = st_q.digits;
	assign DISP_NEG = st_q.neg;
	assign DISP_DP = st_q.dp;
	assign DISP_OVERFLOW = st_q.ovf;
	assign DISP_FAULT_SHOW = st_q.fs; // RQ9
	assign DISP_FAULT = st_q.fault; // RQ9
endmodule // lrf_core

/* File: verification/lrf_core_asserts.sv */
`timescale 1ns/1ps
// ==========================================
// Port checks for the level readout core
module lrf_core_asserts
	import lrf_pkg::*;
#(
	parameter int RELAY_N = 5
) (
	// Clock and reset
	input wire logic CORE_CLK,
	input wire logic RST,
	// Bus
	input wire logic PSEL,
	input wire logic PENABLE,
	input wire logic [7:0] PADDR,
	input wire logic PREADY,
	input wire logic PSLVERR,
	// Measurement and level
	input wire logic MEAS_STB,
	input wire logic MEAS_OK,
	input wire logic FAILSAFE,
	input wire logic [RELAY_N-1:0] FORCE_RELEASE,
	// Display
	input wire logic [16:0] DISP_DIGITS,
	input wire logic DISP_OVERFLOW,
	input wire logic DISP_FAULT_SHOW,
	input wire logic [1:0] DISP_FAULT
);
	default clocking cb @(posedge CORE_CLK); endclocking
	default disable iff (RST);
	// ==========================================
	// Bus handshake: one wait-free access cycle
	a_ready_next: assert property (PSEL && !PENABLE |=> PREADY)
		else $error("no ready after setup");
	a_ready_single: assert property (PREADY |=> !PREADY)
		else $error("ready held too long");
	a_err_unmapped: assert property (PREADY && PADDR > 8'h24 |-> PSLVERR)
		else $error("unmapped access not refused");
	// ==========================================
	// Failsafe entry and exit
	a_valid_clears: assert property (MEAS_STB && MEAS_OK |=> !FAILSAFE)
		else $error("failsafe kept after valid measurement");
	a_entry_invalid: assert property ($rose(FAILSAFE) |-> !$past(MEAS_STB) || !$past(MEAS_OK))
		else $error("failsafe entered on valid measurement");
	a_fault_shown: assert property ($rose(FAILSAFE) |-> ##[0:1] DISP_FAULT_SHOW)
		else $error("fault code not shown");
	a_fault_held: assert property (!$past(MEAS_STB) |-> $stable(DISP_FAULT))
		else $error("fault code changed without a measurement");
	a_release_fs: assert property (FORCE_RELEASE != '0 |-> FAILSAFE || $past(FAILSAFE))
		else $error("relay released outside failsafe");
	// ==========================================
	// Display limits
	a_ovf_blank: assert property (DISP_OVERFLOW |-> DISP_DIGITS == 17'h0)
		else $error("digits shown with overflow");
	a_digit_room: assert property (DISP_DIGITS <= 17'h1869f)
		else $error("too many digits");
	c_failsafe: cover property ($rose(FAILSAFE));
	c_overflow: cover property (DISP_OVERFLOW);
	c_refused: cover property (PSLVERR);
endmodule // lrf_core_asserts

bind lrf_core lrf_core_asserts #(.RELAY_N(RELAY_N)) u_chk (.CORE_CLK(CORE_CLK), .RST(RST),
	.PSEL(PSEL), .PENABLE(PENABLE), .PADDR(PADDR), .PREADY(PREADY), .PSLVERR(PSLVERR),
	.MEAS_STB(MEAS_STB), .MEAS_OK(MEAS_OK), .FAILSAFE(FAILSAFE),
	.FORCE_RELEASE(FORCE_RELEASE), .DISP_DIGITS(DISP_DIGITS),
	.DISP_OVERFLOW(DISP_OVERFLOW), .DISP_FAULT_SHOW(DISP_FAULT_SHOW), .DISP_FAULT(DISP_FAULT));

/* File: verification/lrf_meas_src.sv */
`timescale 1ns/1ps
// ==========================================
// Transducer side: one measurement strobe per bench request
module lrf_meas_src (
	// Clock and request
	input wire logic clk,
	input wire logic req,
	input wire logic req_ok,
	input wire logic [1:0] req_fault,
	input wire logic signed [31:0] req_lvl,
	// Measurement lines
	output logic stb,
	output logic ok,
	output logic [1:0] fault,
	output logic signed [31:0] lvl
);
	// Known levels at time zero
	initial begin
		stb = 1'b0;
		ok = 1'b0;
		fault = 2'h0;
		lvl = 32'sh0;
	end
	// Between strobes ok, fault and lvl toggle so stale values are never trusted
	always @(posedge clk) begin
		stb <= req;
		ok <= req ? req_ok : ~ok;
		fault <= req ? req_fault : ~fault;
		lvl <= req ? req_lvl : ~lvl;
	end
endmodule // lrf_meas_src

/* File: verification/tb_lrf_core.sv */
`timescale 1ns/1ps
module tb_lrf_core;
	import lrf_pkg::*;
	// ==========================================
	// Signals and tables
	logic clk = 0, rst = 1, psel = 0, pen = 0, pwr = 0, req = 0, rok = 0, e;
	logic [7:0] padr = 8'h00;
	logic [31:0] pwd = 32'h0, prd, rd;
	logic [1:0] rf = 2'h0, flt, dp, dflt;
	logic signed [31:0] rl = 32'sh0, lvl, ctl;
	logic prdy, perr, stb, ok, fs, neg, ovf, fsh;
	logic [4:0] frel;
	logic [16:0] dig;
	int miscompares = 0, comparisons = 0, cyc = 0, nfs;
	localparam logic [31:0] SC[4] = '{32'h7d0, 32'h3e8, 32'h186a0, 32'h989298};
	localparam logic [31:0] DS[4] = '{32'h2, 32'h3, 32'h2, 32'h2};
	localparam logic [31:0] DP[4] = '{32'h2, 32'h3, 32'h1, 32'h0};
	localparam logic [31:0] DG[4] = '{32'ha09, 32'h3039, 32'h3039, 32'h0};
	localparam logic [31:0] TG[4] = '{32'h57e4, 32'h3a98, 32'h0, 32'h1b58};
	always #4 clk = ~clk;
	lrf_core #(.TICK_CYCLES(4)) uut (.CORE_CLK(clk), .RST(rst), .PSEL(psel), .PENABLE(pen),
		.PWRITE(pwr), .PADDR(padr), .PWDATA(pwd), .PRDATA(prd), .PREADY(prdy), .PSLVERR(perr),
		.MEAS_STB(stb), .MEAS_OK(ok), .MEAS_FAULT(flt), .MEAS_LEVEL(lvl), .CTRL_LEVEL(ctl),
		.FAILSAFE(fs), .FORCE_RELEASE(frel), .DISP_DIGITS(dig), .DISP_NEG(neg), .DISP_DP(dp),
		.DISP_OVERFLOW(ovf), .DISP_FAULT_SHOW(fsh), .DISP_FAULT(dflt));
	lrf_meas_src src (.clk(clk), .req(req), .req_ok(rok), .req_fault(rf), .req_lvl(rl),
		.stb(stb), .ok(ok), .fault(flt), .lvl(lvl));
	// ==========================================
	// Shared tasks
	task end_sim;
		$display("miscompares %0d comparisons %0d", miscompares, comparisons);
		if (miscompares == 0 && comparisons > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	task chk(input logic [32:0] g, input logic [32:0] x);
		comparisons++;
		if (g !== x) begin
			miscompares++;
			$display("unexpected at %0t: got %h want %h", $time, g, x);
		end
	endtask
	// Request held until ready is seen at a rising edge
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1;
		pwr <= w;
		padr <= a;
		pwd <= d;
		@(posedge clk);
		pen <= 1;
		do begin
			@(posedge clk);
		end while (prdy !== 1);
		rd = prd;
		e = perr;
		psel <= 0;
		pen <= 0;
	endtask
	// Returns half a cycle after the edge at which the core takes the strobe
	task meas(input logic o, input logic [1:0] f, input logic signed [31:0] l);
		@(posedge clk);
		req <= 1;
		rok <= o;
		rf <= f;
		rl <= l;
		@(posedge clk);
		req <= 0;
		@(posedge clk);
		@(negedge clk);
	endtask
	task wait_fs;
		nfs = 0;
		while (fs !== 1 && nfs < 200) begin
			@(posedge clk);
			nfs++;
		end
		@(posedge clk);
		@(negedge clk);
		chk(fs, 1);
	endtask
	// ==========================================
	// Scenarios
	task s_reset;
		apb(0, OFS_CTRL, 0);
		chk(rd, 32'h336);
		apb(0, OFS_SCALE, 0);
		chk(rd, 32'h3e8);
		apb(0, OFS_OFFSET, 0);
		chk(rd, 32'h0);
		apb(0, OFS_DELAY, 0);
		chk(rd, 32'h3e8);
		apb(1, 8'h40, 32'h5);
		chk({e, rd}, 33'h100000000);
	endtask
	task s_disp;
		for (int i = 0; i < 4; i++) begin
			apb(1, OFS_CTRL, 32'h334 | DS[i]);
			apb(1, OFS_SCALE, SC[i]);
			apb(1, OFS_OFFSET, i == 0 ? 32'h3e8 : 32'h0);
			meas(1, 0, 12345);
			chk(ctl, 32'h3039);
			@(posedge clk);
			@(negedge clk);
			chk(dig, DG[i]);
			chk(ovf, i == 3);
			if (i < 3)
				chk(dp, DP[i]);
		end
		apb(1, OFS_SCALE, 32'h3e8);
		// Negative reading through a large negative offset
		apb(1, OFS_OFFSET, 32'hffffb1e0);
		@(posedge clk);
		@(negedge clk);
		chk({neg, dig}, 18'h202fd);
		apb(1, OFS_OFFSET, 32'h0);
	endtask
	task s_choice;
		apb(1, OFS_DELAY, 32'h2);
		apb(1, OFS_FSLVL, 32'h30d40);
		for (int i = 0; i < 4; i++) begin
			apb(1, OFS_CTRL, 32'h34a | (i << 4));
			meas(1, 0, 7000);
			meas(0, i, 0);
			wait_fs();
			chk(nfs > 3, 1);
			chk(ctl, TG[i]);
			chk(dflt, i);
			chk(fsh, 1);
			chk(frel, 32'h3);
			meas(1, 0, 7000);
			chk({fs, ctl}, 33'h1b58);
		end
		// Numeric level in units; percent would give a much lower level
		apb(1, OFS_FSLVL, 32'hfa0);
		apb(1, OFS_CTRL, 32'h30a);
		meas(1, 0, 7000);
		meas(0, 0, 0);
		wait_fs();
		chk(ctl, 32'hfa0);
		meas(1, 0, 7000);
		chk({fs, ctl}, 33'h1b58);
	endtask
	task s_mode3;
		apb(1, OFS_RATE, 32'h01f403e8);
		apb(1, OFS_CTRL, 32'h31e);
		meas(0, 0, 0);
		wait_fs();
		repeat (8) @(posedge clk);
		@(negedge clk);
		chk(ctl > 7000 && ctl <= 11000, 1);
		meas(1, 0, 3000);
		chk({fs, ctl}, 33'hbb8);
	endtask
	task s_mode1;
		apb(1, OFS_CTRL, 32'h316);
		meas(0, 0, 0);
		wait_fs();
		chk(ctl < 15000, 1);
		meas(1, 0, 3000);
		chk({fs, ctl > 3000}, 2'h1);
		repeat (60) @(posedge clk);
		@(negedge clk);
		chk(ctl, 32'hbb8);
	endtask
	// ==========================================
	// Run and watchdog
	always @(posedge clk) begin
		cyc++;
		if (cyc == 6000) begin
			miscompares++;
			end_sim();
		end
	end
	initial begin
		repeat (2) @(posedge clk);
		rst <= 0;
		s_reset();
		s_disp();
		s_choice();
		s_mode3();
		s_mode1();
		end_sim();
	end
endmodule // tb_lrf_core
